// File: design/uart_mode_control_regs.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "uart_mode_consts.svh"

// ****************************************
// One serial port
// ****************************************
module uart_port (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// Device power state
	input wire logic idle_mode,
	input wire logic sleep_mode,
	// Register access
	input uart_mode_pkg::bus_op_type op,
	output uart_mode_pkg::reg_view_type regs,
	// Pins
	input wire logic rx_pin,
	input wire logic cts_pin,
	output uart_mode_pkg::pin_out_type pins
);
	uart_mode_pkg::port_state_type state_reg;
	uart_mode_pkg::port_state_type state_next;
	logic on;
	logic run;
	logic infrared_codec_enable;
	logic rx_in;
	logic cts_ok;
	logic tx_end;
	logic rx_end;
	logic [1:0] pu;
	logic [3:0] sub_max;
	logic [31:0] sta;

	function automatic logic [31:0] apply_alias(input logic [31:0] old, input logic [31:0] w,
		input logic [3:0] a, input logic [31:0] mask);
		logic [31:0] r;
		case (a)
			`ALIAS_CLR_OFS: r = old & ~w;
			`ALIAS_SET_OFS: r = old | w;
			`ALIAS_INV_OFS: r = old ^ w;
			default: r = w;
		endcase
		return (old & ~mask) | (r & mask);
	endfunction

	assign regs = state_reg.regs;
	assign pins = state_reg.pins;

	always_comb begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		state_next.pins.wake = 1'b0;
		on = state_reg.regs.mode[`MODE_ON_BIT];
		run = on & ~(state_reg.regs.mode[`MODE_IDLE_STOP_BIT] & idle_mode);
		infrared_codec_enable = state_reg.regs.mode[`MODE_IR_BIT];
		pu = state_reg.regs.mode[`MODE_PU_MSB:`MODE_PU_LSB];
		sub_max = state_reg.regs.mode[`MODE_FAST_BIT] ? `SUB_MAX_FAST : `SUB_MAX_STD;
		if (state_reg.regs.mode[`MODE_LOOP_BIT]) begin
			rx_in = state_reg.tx_level;
		end else begin
			rx_in = infrared_codec_enable ? ~state_reg.rx_line : state_reg.rx_line;
		end
		cts_ok = (pu != `PU_FLOW) | ~state_reg.cts_line;
		tx_end = run & state_reg.tick & (state_reg.tx_sub == sub_max);
		rx_end = run & state_reg.tick & (state_reg.rx_sub == sub_max);
		sta = state_reg.regs.status;

		// ****************************************
		// Register writes and reads
		// ****************************************
		if (op.wr) begin
			case (op.sel)
				`SEL_MODE: begin
					state_next.regs.mode = apply_alias(state_reg.regs.mode, op.wdata,
						op.alias_ofs, `MODE_WMASK);
				end
				`SEL_STATUS: begin
					sta = apply_alias(state_reg.regs.status, op.wdata, op.alias_ofs,
						`STATUS_WMASK | `OERR_CLEAR_MASK);
					sta[`STA_OERR_BIT] = sta[`STA_OERR_BIT] & state_reg.regs.status[`STA_OERR_BIT];
				end
				`SEL_TXDATA: begin
					if (!state_reg.tx_full && on) begin
						state_next.tx_buf = 8'(apply_alias(32'h0, op.wdata, op.alias_ofs, `DATA_MASK));
						state_next.tx_full = 1'b1;
					end
				end
				`SEL_BAUD: begin
					state_next.regs.baud = apply_alias(state_reg.regs.baud, op.wdata,
						op.alias_ofs, `BAUD_WMASK);
				end
				default: begin
				end
			endcase
		end
		if (op.rd && op.sel == `SEL_RXDATA && op.alias_ofs == `ALIAS_BASE_OFS) begin
			sta[`STA_RXDA_BIT] = 1'b0;
		end

		// ****************************************
		// Pin synchronisers and baud prescaler
		// ****************************************
		if (on) begin
			state_next.rx_sync = {state_reg.rx_sync[1:0], rx_pin};
			state_next.cts_sync = {state_reg.cts_sync[1:0], cts_pin};
			if (state_reg.rx_sync[2] == state_reg.rx_sync[1]) begin
				state_next.rx_line = state_reg.rx_sync[2];
			end
			if (state_reg.cts_sync[2] == state_reg.cts_sync[1]) begin
				state_next.cts_line = state_reg.cts_sync[2];
			end
			state_next.rx_prev = rx_in;
			if (state_reg.regs.mode[`MODE_WAKE_BIT] && sleep_mode && state_reg.rx_prev && !rx_in) begin
				state_next.pins.wake = 1'b1;
			end
		end
		if (run) begin
			if (state_reg.pre_cnt == 16'h0) begin
				state_next.pre_cnt = state_reg.regs.baud[15:0];
				state_next.tick = 1'b1;
				state_next.pins.bclk = ~state_reg.pins.bclk;
			end else begin
				state_next.pre_cnt = state_reg.pre_cnt - 16'h1;
			end
		end

		// ****************************************
		// Transmitter
		// ****************************************
		if (run && state_reg.tick && state_reg.tx_state != uart_mode_pkg::TX_IDLE) begin
			state_next.tx_sub = tx_end ? 4'h0 : state_reg.tx_sub + 4'h1;
		end
		case (state_reg.tx_state)
			uart_mode_pkg::TX_IDLE: begin
				state_next.tx_level = 1'b1;
				if (run && state_reg.tx_full && sta[`STA_TXEN_BIT] && cts_ok) begin
					state_next.tx_shift = state_reg.tx_buf;
					state_next.tx_full = 1'b0;
					state_next.tx_sub = 4'h0;
					state_next.tx_bit = 3'h0;
					state_next.tx_level = 1'b0;
					state_next.tx_state = uart_mode_pkg::TX_START;
				end
			end
			uart_mode_pkg::TX_START: begin
				if (tx_end) begin
					state_next.tx_level = state_reg.tx_shift[0];
					state_next.tx_state = uart_mode_pkg::TX_DATA;
				end
			end
			uart_mode_pkg::TX_DATA: begin
				if (tx_end) begin
					if (state_reg.tx_bit == `LAST_DATA_BIT) begin
						state_next.tx_level = 1'b1;
						state_next.tx_state = uart_mode_pkg::TX_STOP;
					end else begin
						state_next.tx_bit = state_reg.tx_bit + 3'h1;
						state_next.tx_shift = {1'b0, state_reg.tx_shift[7:1]};
						state_next.tx_level = state_reg.tx_shift[1];
					end
				end
			end
			uart_mode_pkg::TX_STOP: begin
				if (tx_end) begin
					state_next.tx_state = uart_mode_pkg::TX_IDLE;
				end
			end
			default: begin
				state_next.tx_state = uart_mode_pkg::TX_IDLE;
			end
		endcase

		// ****************************************
		// Receiver
		// ****************************************
		if (run && state_reg.tick && state_reg.rx_state != uart_mode_pkg::RX_IDLE) begin
			state_next.rx_sub = rx_end ? 4'h0 : state_reg.rx_sub + 4'h1;
		end
		case (state_reg.rx_state)
			uart_mode_pkg::RX_IDLE: begin
				if (run && sta[`STA_RXEN_BIT] && state_reg.rx_prev && !rx_in) begin
					state_next.rx_sub = 4'h0;
					state_next.rx_bit = 3'h0;
					state_next.rx_state = uart_mode_pkg::RX_START;
				end
			end
			uart_mode_pkg::RX_START: begin
				// A start bit must still be low at mid-bit, so glitches are dropped.
				if (run && state_reg.tick && state_reg.rx_sub == (sub_max >> 1)) begin
					state_next.rx_sub = 4'h0;
					state_next.rx_state = rx_in ? uart_mode_pkg::RX_IDLE : uart_mode_pkg::RX_DATA;
				end
			end
			uart_mode_pkg::RX_DATA: begin
				if (rx_end) begin
					state_next.rx_shift = {rx_in, state_reg.rx_shift[7:1]};
					if (state_reg.rx_bit == `LAST_DATA_BIT) begin
						state_next.rx_state = uart_mode_pkg::RX_STOP;
					end else begin
						state_next.rx_bit = state_reg.rx_bit + 3'h1;
					end
				end
			end
			uart_mode_pkg::RX_STOP: begin
				if (rx_end) begin
					sta[`STA_FERR_BIT] = ~rx_in;
					// The unread word is kept; the new one is lost and flagged.
					if (sta[`STA_RXDA_BIT]) begin
						sta[`STA_OERR_BIT] = 1'b1;
					end else begin
						state_next.regs.rx_data = {24'h0, state_reg.rx_shift};
						sta[`STA_RXDA_BIT] = 1'b1;
					end
					state_next.rx_state = uart_mode_pkg::RX_IDLE;
				end
			end
			default: begin
				state_next.rx_state = uart_mode_pkg::RX_IDLE;
			end
		endcase

		// ****************************************
		// Disable and status view
		// ****************************************
		// Disabled port parks.
		if (!on) begin
			state_next.tx_state = uart_mode_pkg::TX_IDLE;
			state_next.rx_state = uart_mode_pkg::RX_IDLE;
			state_next.tx_full = 1'b0;
			state_next.tx_level = 1'b1;
			state_next.tx_sub = 4'h0;
			state_next.rx_sub = 4'h0;
			state_next.pre_cnt = 16'h0;
			state_next.pins.bclk = 1'b0;
		end
		sta[`STA_TXBF_BIT] = state_next.tx_full;
		sta[`STA_TRANSMIT_SHIFT_EMPTY_BIT] = (state_next.tx_state == uart_mode_pkg::TX_IDLE) & ~state_next.tx_full;
		sta[`STA_RECEIVER_IDLE_FLAG_BIT] = state_next.rx_state == uart_mode_pkg::RX_IDLE;
		state_next.regs.status = sta;

		// ****************************************
		// Pin drive and ownership
		// ****************************************
		// Infrared encoder pulse.
		if (state_next.regs.mode[`MODE_IR_BIT]) begin
			state_next.pins.tx = ~state_next.tx_level & (state_next.tx_sub < `IR_PULSE_TICKS)
				& (state_next.tx_state != uart_mode_pkg::TX_IDLE);
		end else begin
			state_next.pins.tx = state_next.tx_level & ~sta[`STA_BREAK_BIT];
		end
		state_next.pins.tx = state_next.pins.tx ^ sta[`STA_TXINV_BIT];
		if (state_next.regs.mode[`MODE_RTS_MODE_BIT]) begin
			state_next.pins.rts_n = state_next.tx_state == uart_mode_pkg::TX_IDLE;
		end else begin
			state_next.pins.rts_n = sta[`STA_RXDA_BIT];
		end
		state_next.pins.rx_own = state_next.regs.mode[`MODE_ON_BIT];
		state_next.pins.tx_own = state_next.regs.mode[`MODE_ON_BIT] & sta[`STA_TXEN_BIT];
		case (state_next.regs.mode[`MODE_PU_MSB:`MODE_PU_LSB])
			`PU_TXRX: {state_next.pins.rts_own, state_next.pins.cts_own, state_next.pins.bclk_own} = 3'h0;
			`PU_RTS: {state_next.pins.rts_own, state_next.pins.cts_own, state_next.pins.bclk_own} = 3'h4;
			`PU_FLOW: {state_next.pins.rts_own, state_next.pins.cts_own, state_next.pins.bclk_own} = 3'h6;
			default: {state_next.pins.rts_own, state_next.pins.cts_own, state_next.pins.bclk_own} = 3'h1;
		endcase
		if (!state_next.regs.mode[`MODE_ON_BIT]) begin
			{state_next.pins.rts_own, state_next.pins.cts_own, state_next.pins.bclk_own} = 3'h0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
			state_reg.regs.mode <= `MODE_RESET;
			state_reg.regs.status <= `STATUS_RESET;
			state_reg.regs.baud <= `BAUD_RESET;
			state_reg.regs.rx_data <= `RXDATA_RESET;
			state_reg.tx_level <= 1'b1;
			state_reg.rx_line <= 1'b1;
			state_reg.cts_line <= 1'b1;
			// Synchronisers start at the idle line level, so enabling gives no false edge.
			state_reg.rx_sync <= 3'h7;
			state_reg.cts_sync <= 3'h7;
			state_reg.rx_prev <= 1'b1;
			state_reg.pins.tx <= 1'b1;
			state_reg.pins.rts_n <= 1'b1;
			state_reg.tx_state <= uart_mode_pkg::TX_IDLE;
			state_reg.rx_state <= uart_mode_pkg::RX_IDLE;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end
endmodule // uart_port

// ****************************************
// Two ports behind one register port
// ****************************************
module uart_mode_control_regs (
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CE,
	// Register port
	input wire logic [15:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// Device power state
	input wire logic IDLE_MODE,
	input wire logic SLEEP_MODE,
	// Serial pins, index 0 is the first port
	input wire logic [1:0] SERIAL_IN_PIN,
	input wire logic [1:0] CLEAR_TO_SEND_PIN,
	output uart_mode_pkg::pin_out_type [1:0] PORT_PINS
);
	localparam logic [15:0] OFS_TABLE [2][5] = '{
		'{`U1_MODE_OFS, `U1_STATUS_OFS, `U1_TXDATA_OFS, `U1_RXDATA_OFS, `U1_BAUD_OFS},
		'{`U2_MODE_OFS, `U2_STATUS_OFS, `U2_TXDATA_OFS, `U2_RXDATA_OFS, `U2_BAUD_OFS}};
	uart_mode_pkg::top_state_type state_reg;
	uart_mode_pkg::top_state_type state_next;
	uart_mode_pkg::bus_op_type [1:0] ops;
	uart_mode_pkg::reg_view_type [1:0] views;
	logic hit;
	logic unit;
	logic [2:0] sel;

	always_comb begin
		hit = 1'b0;
		unit = 1'b0;
		sel = 3'h0;
		for (int u = 0; u < 2; u++) begin
			for (int r = 0; r < 5; r++) begin
				if (ADDR[15:4] == OFS_TABLE[u][r][15:4] && ADDR[1:0] == 2'h0) begin
					hit = 1'b1;
					unit = u[0];
					sel = r[2:0];
				end
			end
		end
		for (int u = 0; u < 2; u++) begin
			ops[u].wr = WR & hit & (unit == u[0]);
			ops[u].rd = RD & hit & (unit == u[0]);
			ops[u].sel = sel;
			ops[u].alias_ofs = ADDR[3:0];
			ops[u].wdata = WDATA;
		end
		// Read data stands one cycle only; alias and unmapped reads give zero.
		state_next.rdata = 32'h0;
		if (RD && hit && ADDR[3:0] == `ALIAS_BASE_OFS) begin
			case (sel)
				`SEL_MODE: state_next.rdata = views[unit].mode;
				`SEL_STATUS: state_next.rdata = views[unit].status;
				`SEL_RXDATA: state_next.rdata = views[unit].rx_data;
				`SEL_BAUD: state_next.rdata = views[unit].baud;
				default: state_next.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_reg <= '0;
		end else if (CE) begin
			state_reg <= state_next;
		end
	end

	assign RDATA = state_reg.rdata;

	for (genvar g = 0; g < 2; g++) begin : gen_port
		uart_port port_inst (
			.clk(CLK),
			.resetn(RESETN),
			.ce(CE),
			.idle_mode(IDLE_MODE),
			.sleep_mode(SLEEP_MODE),
			.op(ops[g]),
			.regs(views[g]),
			.rx_pin(SERIAL_IN_PIN[g]),
			.cts_pin(CLEAR_TO_SEND_PIN[g]),
			.pins(PORT_PINS[g])
		);
	end
endmodule // uart_mode_control_regs

// File: design/uart_mode_consts.svh
`ifndef UART_MODE_CONSTS_SVH
`define UART_MODE_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define U1_MODE_OFS 16'h6000
`define U1_STATUS_OFS 16'h6010
`define U1_TXDATA_OFS 16'h6020
`define U1_RXDATA_OFS 16'h6030
`define U1_BAUD_OFS 16'h6040
`define U2_MODE_OFS 16'h6200
`define U2_STATUS_OFS 16'h6210
`define U2_TXDATA_OFS 16'h6220
`define U2_RXDATA_OFS 16'h6230
`define U2_BAUD_OFS 16'h6240
`define ALIAS_BASE_OFS 4'h0
`define ALIAS_CLR_OFS 4'h4
`define ALIAS_SET_OFS 4'h8
`define ALIAS_INV_OFS 4'hc

// ****************************************
// Register selectors
// ****************************************
`define SEL_MODE 3'h0
`define SEL_STATUS 3'h1
`define SEL_TXDATA 3'h2
`define SEL_RXDATA 3'h3
`define SEL_BAUD 3'h4

// ****************************************
// Field positions
// ****************************************
`define MODE_ON_BIT 15
`define MODE_IDLE_STOP_BIT 13
`define MODE_IR_BIT 12
`define MODE_RTS_MODE_BIT 11
`define MODE_PU_MSB 9
`define MODE_PU_LSB 8
`define MODE_WAKE_BIT 7
`define MODE_LOOP_BIT 6
`define MODE_FAST_BIT 3
`define STA_TXINV_BIT 13
`define STA_RXEN_BIT 12
`define STA_BREAK_BIT 11
`define STA_TXEN_BIT 10
`define STA_TXBF_BIT 9
`define STA_TRANSMIT_SHIFT_EMPTY_BIT 8
`define STA_RECEIVER_IDLE_FLAG_BIT 4
`define STA_FERR_BIT 2
`define STA_OERR_BIT 1
`define STA_RXDA_BIT 0
`define PU_TXRX 2'h0
`define PU_RTS 2'h1
`define PU_FLOW 2'h2
`define PU_BCLK 2'h3

// ****************************************
// Masks and reset values
// ****************************************
`define MODE_WMASK 32'h0000bbff
`define STATUS_WMASK 32'h01fffce0
`define OERR_CLEAR_MASK 32'h00000002
`define BAUD_WMASK 32'h0000ffff
`define DATA_MASK 32'h000000ff
`define MODE_RESET 32'h00000000
`define STATUS_RESET 32'h00000110
`define BAUD_RESET 32'h00000000
`define RXDATA_RESET 32'h00000000

// ****************************************
// Timing counts
// ****************************************
`define SUB_MAX_STD 4'hf
`define SUB_MAX_FAST 4'h3
`define IR_PULSE_TICKS 4'h3
`define LAST_DATA_BIT 3'h7

`endif

// File: design/uart_mode_pkg.sv
package uart_mode_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] sel;
		logic [3:0] alias_ofs;
		logic [31:0] wdata;
	} bus_op_type;
	typedef struct packed {
		logic [31:0] mode;
		logic [31:0] status;
		logic [31:0] baud;
		logic [31:0] rx_data;
	} reg_view_type;
	typedef struct packed {
		logic tx;
		logic tx_own;
		logic rx_own;
		logic rts_n;
		logic rts_own;
		logic bclk;
		logic bclk_own;
		logic cts_own;
		logic wake;
	} pin_out_type;
	typedef struct packed {
		reg_view_type regs;
		pin_out_type pins;
		logic [7:0] tx_buf;
		logic tx_full;
		tx_state_type tx_state;
		logic [7:0] tx_shift;
		logic [2:0] tx_bit;
		logic [3:0] tx_sub;
		logic tx_level;
		rx_state_type rx_state;
		logic [7:0] rx_shift;
		logic [2:0] rx_bit;
		logic [3:0] rx_sub;
		logic [2:0] rx_sync;
		logic rx_line;
		logic [2:0] cts_sync;
		logic cts_line;
		logic rx_prev;
		logic [15:0] pre_cnt;
		logic tick;
	} port_state_type;
	typedef struct packed {
		logic [31:0] rdata;
	} top_state_type;
endpackage

// File: bench/uart_mode_props.sv
`timescale 1ns/1ps
// ****
// Checks on the first port
// ****
module uart_mode_props (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CE,
	// Register port
	input wire logic [15:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	// Power state and pins
	input wire logic SLEEP_MODE,
	input uart_mode_pkg::pin_out_type [1:0] PORT_PINS
);
	logic [15:0] m_reg;
	logic [15:0] w;
	uart_mode_pkg::pin_out_type p;
	assign w = WDATA[15:0] & 16'hbbff;
	assign p = PORT_PINS[0];
	// A shadow of the mode word lets pin owners be predicted without the body.
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			m_reg <= 16'h0000;
		end else if (CE && WR) begin
			case (ADDR)
				16'h6000: m_reg <= w;
				16'h6004: m_reg <= m_reg & ~w;
				16'h6008: m_reg <= m_reg | w;
				16'h600c: m_reg <= m_reg ^ w;
				default: m_reg <= m_reg;
			endcase
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	AST_MODE_READ: assert property ($past(RD) && $past(ADDR) == 16'h6000 |->
		RDATA == {16'h0000, $past(m_reg)}) else $error("mode read back wrong");
	AST_OFF_FREE: assert property ($stable(m_reg) && !m_reg[15] |->
		!(p.tx_own || p.rx_own || p.rts_own || p.bclk_own || p.cts_own))
		else $error("disabled port holds a pin");
	AST_RX_OWN: assert property ($stable(m_reg) && m_reg[15] |-> p.rx_own)
		else $error("enabled port left receive pin");
	AST_CTS_OWN: assert property ($stable(m_reg) && m_reg[15] |->
		p.cts_own == (m_reg[9:8] == 2'h2)) else $error("clear pin owner wrong");
	AST_RTS_OWN: assert property ($stable(m_reg) && m_reg[15] |->
		p.rts_own == (m_reg[9:8] == 2'h1 || m_reg[9:8] == 2'h2))
		else $error("request pin owner wrong");
	AST_BCLK_OWN: assert property ($stable(m_reg) && m_reg[15] |->
		p.bclk_own == (m_reg[9:8] == 2'h3)) else $error("baud clock owner wrong");
	AST_WAKE_CAUSE: assert property (p.wake |-> $past(m_reg[7]) && $past(SLEEP_MODE))
		else $error("wake without enable and sleep");
	AST_WAKE_PULSE: assert property (p.wake |=> !p.wake)
		else $error("wake longer than one cycle");
endmodule // uart_mode_props

bind uart_mode_control_regs uart_mode_props i_props (.CLK(CLK), .RESETN(RESETN), .CE(CE),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.SLEEP_MODE(SLEEP_MODE), .PORT_PINS(PORT_PINS));

// File: bench/serial_peer.sv
`timescale 1ns/1ps
// ****
// Remote serial device
// ****
module serial_peer (
	// Clock
	input wire logic clk,
	// Port side
	input uart_mode_pkg::pin_out_type [1:0] pins,
	output logic [1:0] line_out,
	output logic [1:0] cts_n
);
	// A real sender drives the mark level between frames.
	initial begin
		line_out = 2'h3;
		cts_n = 2'h3;
	end
	// Frames are eight data bits, no parity, one stop, sixteen cycles a bit.
	task automatic send(input int q, input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			if (q == 0) begin
				line_out[0] <= f[i];
			end else begin
				line_out[1] <= f[i];
			end
			repeat (15) @(posedge clk);
		end
	endtask
	task automatic set_cts(input int q, input logic v);
		@(posedge clk);
		if (q == 0) begin
			cts_n[0] <= v;
		end else begin
			cts_n[1] <= v;
		end
	endtask
	task automatic take(input int q, output logic [7:0] b, output logic ok);
		int t;
		t = 0;
		b = 8'h00;
		while (pins[q].tx !== 1'b0 && t < 400) begin
			@(posedge clk);
			t++;
		end
		ok = (t < 400);
		repeat (8) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (16) @(posedge clk);
			b[i] = pins[q].tx;
		end
	endtask
endmodule // serial_peer

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic idle = 1'b0;
	logic sleep = 1'b0;
	logic [31:0] rdata;
	logic [1:0] line;
	logic [1:0] cts_n;
	uart_mode_pkg::pin_out_type [1:0] pins;
	int num_errors = 0;
	int cmp_count = 0;
	int n;
	logic [7:0] b;
	logic ok;
	always #50 clk = ~clk;
	uart_mode_control_regs i_dut (.CLK(clk), .RESETN(resetn), .CE(1'b1), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IDLE_MODE(idle),
		.SLEEP_MODE(sleep), .SERIAL_IN_PIN(line), .CLEAR_TO_SEND_PIN(cts_n), .PORT_PINS(pins));
	serial_peer i_peer (.clk(clk), .pins(pins), .line_out(line), .cts_n(cts_n));
	// ****
	// Access and compare tasks
	// ****
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input string nm, input logic [15:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(nm, rdata, e);
	endtask
	task automatic conclude;
		$display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		for (int q = 0; q < 2; q++) begin
			for (int r = 0; r < 5; r++) begin
				rd_chk("reset", 16'h6000 + 16'(q * 512 + r * 16), (r == 1) ? 32'h110 : 32'h0);
			end
		end
		wr_reg(16'h6000, 32'hffffffff);
		rd_chk("mode base", 16'h6000, 32'h0000bbff);
		wr_reg(16'h6004, 32'h0000ff00);
		rd_chk("mode clear", 16'h6000, 32'h000000ff);
		wr_reg(16'h6008, 32'h00008000);
		rd_chk("mode set", 16'h6000, 32'h000080ff);
		wr_reg(16'h600c, 32'h000000ff);
		rd_chk("mode invert", 16'h6000, 32'h00008000);
		rd_chk("alias read", 16'h6004, 32'h0);
		rd_chk("unmapped", 16'h6050, 32'h0);
		for (int u = 0; u < 4; u++) begin
			wr_reg(16'h6000, 32'h00008000 | (32'(u) << 8));
			cyc(2);
			chk("owners", {pins[0].rx_own, pins[0].cts_own, pins[0].rts_own, pins[0].bclk_own},
				{1'b1, u == 2, u == 1 || u == 2, u == 3});
		end
		wr_reg(16'h6048, 32'h00010003);
		rd_chk("baud set", 16'h6040, 32'h00000003);
		ok = pins[0].bclk;
		n = 0;
		repeat (40) begin
			cyc(1);
			if (pins[0].bclk !== ok) begin
				n++;
			end
			ok = pins[0].bclk;
		end
		chk("baud clock", n, 32'h0000000a);
		wr_reg(16'h6044, 32'h0000ffff);
		rd_chk("baud clear", 16'h6040, 32'h00000000);
		wr_reg(16'h6000, 32'h00008000);
		wr_reg(16'h6010, 32'h00001400);
		fork
			i_peer.take(0, b, ok);
			wr_reg(16'h6020, 32'h00000041);
		join
		chk("sent byte", {ok, b}, 32'h141);
		chk("tx owner", pins[0].tx_own, 1'b1);
		i_peer.send(0, 8'ha5);
		cyc(40);
		rd_chk("rx byte", 16'h6030, 32'h000000a5);
		wr_reg(16'h6000, 32'h00008200);
		i_peer.send(0, 8'h5a);
		cyc(40);
		chk("flow full", pins[0].rts_n, 1'b1);
		rd_chk("flow byte", 16'h6030, 32'h0000005a);
		cyc(2);
		chk("flow empty", pins[0].rts_n, 1'b0);
		wr_reg(16'h6020, 32'h000000c3);
		cyc(20);
		rd_chk("clear blocks", 16'h6010, 32'h00001610);
		fork
			i_peer.take(0, b, ok);
			i_peer.set_cts(0, 1'b0);
		join
		chk("clear sent", {ok, b}, 32'h000001c3);
		wr_reg(16'h6000, 32'h00008a00);
		cyc(2);
		chk("simplex busy", pins[0].rts_n, 1'b0);
		cyc(30);
		chk("simplex idle", pins[0].rts_n, 1'b1);
		wr_reg(16'h6000, 32'h00008040);
		wr_reg(16'h6020, 32'h0000003c);
		cyc(200);
		rd_chk("loopback", 16'h6030, 32'h0000003c);
		wr_reg(16'h6000, 32'h00009000);
		cyc(4);
		chk("infrared idle", pins[0].tx, 1'b0);
		wr_reg(16'h6000, 32'h00008000);
		cyc(4);
		chk("plain idle", pins[0].tx, 1'b1);
		@(posedge clk);
		sleep <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			wr_reg(16'h6000, k ? 32'h00008000 : 32'h00008080);
			n = 0;
			fork
				i_peer.send(0, 8'h00);
				repeat (200) begin
					cyc(1);
					if (pins[0].wake === 1'b1) n++;
				end
			join
			chk("wake", n > 0, k == 0);
		end
		@(posedge clk);
		sleep <= 1'b0;
		idle <= 1'b1;
		wr_reg(16'h6210, 32'h00001000);
		for (int k = 0; k < 2; k++) begin
			wr_reg(16'h6200, k ? 32'h00008000 : 32'h0000a000);
			i_peer.send(1, 8'h96);
			cyc(40);
			rd_chk("idle rx", 16'h6230, k ? 32'h00000096 : 32'h0);
		end
		@(posedge clk);
		idle <= 1'b0;
		wr_reg(16'h6000, 32'h00000000);
		cyc(2);
		chk("off owners", {pins[0].tx_own, pins[0].rx_own, pins[0].cts_own}, 3'h0);
		rd_chk("mode off", 16'h6000, 32'h0);
		conclude();
	end
endmodule // tb
